// [hdl/asyntx_pkg.sv]
// asyntx_pkg: register map, field positions, reset values, timing
// assumes: used by asyntx_top and the bench, always with package-qualified names
package asyntx_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_CTRL1 = 4'h8;
  localparam logic [3:0] ADDR_CTRL2 = 4'hc;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int C1_NINTH = 0;
  localparam int C1_WLEN = 1;
  localparam int C2_BREAK = 0;
  localparam int C2_RXEN = 1;
  localparam int C2_TXEN = 2;
  localparam int C2_DONEIE = 3;
  localparam int C2_EMPTYIE = 4;
  localparam int C2_DIV_LSB = 8;
  localparam int ST_DONE = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_BUSY = 2;
  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [1:0] CTRL1_RST = 2'h0;
  localparam logic [4:0] CTRL2_FLAGS_RST = 5'h00;
  localparam logic [15:0] DIV_RST = 16'h00f9;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // timing: fastest rate 500K baud at 125 MHz
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 125000000;
  localparam int MAX_BAUD = 500000;
  localparam int MIN_DIV = CLK_HZ / MAX_BAUD;
  localparam logic [15:0] MIN_DIV_M1 = 16'(MIN_DIV - 1);
  // ---------------------------------------------------------------
  // transmitter states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_IDLE = 3'b001,
    ST_PREAMBLE = 3'b010,
    ST_FRAME = 3'b011,
    ST_BRK = 3'b100,
    ST_MARK = 3'b101
  } asyntx_state_t;
endpackage : asyntx_pkg

// [hdl/asyntx_top.sv]
// asyntx_top: async serial transmitter behind an AXI4-Lite slave
// assumes: single 125 MHz clock, synchronous active-low reset
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module asyntx_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_irq_mask,
  output logic tx_line_o,
  output logic tx_line_oe,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
  logic [3:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [3:0] ws_reg, ws_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic [1:0] c1_reg, c1_next;
  logic [4:0] c2_reg, c2_next;
  logic [15:0] div_reg, div_next, bcnt_reg, bcnt_next;
  logic [8:0] hold_reg, hold_next;
  logic hold_full_reg, hold_full_next;
  logic empty_reg, empty_next, done_reg, done_next;
  logic armed_reg, armed_next, pend_idle_reg, pend_idle_next;
  logic [10:0] sh_reg, sh_next;
  logic [3:0] nbit_reg, nbit_next;
  asyntx_pkg::asyntx_state_t st_reg, st_next;
  logic line_reg, line_next, oe_reg, oe_next, irq_reg, irq_next;
  logic tick, wr_go, rd_go, data_wr, txen, brk, nine, frame_end;
  logic [3:0] frame_bits;

  function automatic logic [10:0] frame_of(input logic [8:0] d,
                                           input logic n);
    frame_of = n ? {1'b1, d, 1'b0} : {2'h3, d[7:0], 1'b0};
  endfunction : frame_of

  assign txen = c2_reg[asyntx_pkg::C2_TXEN];
  assign brk = c2_reg[asyntx_pkg::C2_BREAK];
  assign nine = c1_reg[asyntx_pkg::C1_WLEN];
  // stop bit plus data plus start
  assign frame_bits = (nine ? asyntx_pkg::BITS_9 : asyntx_pkg::BITS_8)
                      + 4'h2;
  assign tick = (bcnt_reg == 16'h0000);
  assign wr_go = aw_reg && w_reg && !b_reg;
  assign rd_go = s_axi_arvalid && !r_reg;
  assign data_wr = wr_go && (awa_reg == asyntx_pkg::ADDR_DATA);
  assign frame_end = tick && (nbit_reg == 4'h1);

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  always_comb begin
    aw_next = aw_reg;
    w_next = w_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    b_next = b_reg;
    br_next = br_reg;
    r_next = r_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (s_axi_awvalid && !aw_reg) begin
      aw_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_reg) begin
      w_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      b_next = 1'b1;
      br_next = (awa_reg[1:0] == 2'h0) ? asyntx_pkg::RESP_OKAY
                                       : asyntx_pkg::RESP_SLVERR;
    end else if (b_reg && s_axi_bready) begin
      b_next = 1'b0;
    end
    if (rd_go) begin
      r_next = 1'b1;
      rr_next = asyntx_pkg::RESP_OKAY;
      case (s_axi_araddr)
        asyntx_pkg::ADDR_STATUS: begin
          rd_next = 32'h0;
          rd_next[asyntx_pkg::ST_DONE] = done_reg;
          rd_next[asyntx_pkg::ST_EMPTY] = empty_reg;
          rd_next[asyntx_pkg::ST_BUSY] = (st_reg != asyntx_pkg::ST_IDLE)
                                         && (st_reg != asyntx_pkg::ST_OFF);
        end
        asyntx_pkg::ADDR_DATA: rd_next = {23'h0, hold_reg};
        asyntx_pkg::ADDR_CTRL1: rd_next = {30'h0, c1_reg};
        asyntx_pkg::ADDR_CTRL2: rd_next = {div_reg, 11'h0, c2_reg};
        default: begin
          rd_next = 32'h0;
          rr_next = asyntx_pkg::RESP_SLVERR;
        end
      endcase
    end else if (r_reg && s_axi_rready) begin
      r_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awa_reg <= 4'h0;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      b_reg <= 1'b0;
      br_reg <= 2'h0;
      r_reg <= 1'b0;
      rd_reg <= 32'h0;
      rr_reg <= 2'h0;
    end else begin
      aw_reg <= aw_next;
      w_reg <= w_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      b_reg <= b_next;
      br_reg <= br_next;
      r_reg <= r_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
    end
  end

  assign s_axi_awready = !aw_reg;
  assign s_axi_wready = !w_reg;
  assign s_axi_bvalid = b_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = !r_reg;
  assign s_axi_rvalid = r_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;

  // ---------------------------------------------------------------
  // control, flags and transmitter
  // ---------------------------------------------------------------
  always_comb begin
    c1_next = c1_reg;
    c2_next = c2_reg;
    div_next = div_reg;
    hold_next = hold_reg;
    hold_full_next = hold_full_reg;
    empty_next = empty_reg;
    done_next = done_reg;
    armed_next = armed_reg;
    pend_idle_next = pend_idle_reg;
    sh_next = sh_reg;
    nbit_next = nbit_reg;
    st_next = st_reg;
    bcnt_next = tick ? div_reg : bcnt_reg - 16'h0001;
    if (rd_go && s_axi_araddr == asyntx_pkg::ADDR_STATUS) begin
      armed_next = 1'b1;
    end
    if (wr_go && awa_reg == asyntx_pkg::ADDR_CTRL1 && ws_reg[0]) begin
      c1_next = wd_reg[1:0];
    end
    if (wr_go && awa_reg == asyntx_pkg::ADDR_CTRL2) begin
      if (ws_reg[0]) begin
        c2_next = wd_reg[4:0];
        if (!wd_reg[asyntx_pkg::C2_TXEN] && txen) begin
          hold_full_next = 1'b0; // buffered byte lost on disable
        end
        if (wd_reg[asyntx_pkg::C2_TXEN] && !txen) begin
          pend_idle_next = 1'b1;
        end
      end
      if (ws_reg[1] && ws_reg[2]) begin
        div_next = (wd_reg[31:16] < asyntx_pkg::MIN_DIV_M1)
                   ? asyntx_pkg::MIN_DIV_M1 : wd_reg[31:16];
      end
    end
    if (data_wr) begin
      if (armed_reg) begin
        empty_next = 1'b0;
        done_next = 1'b0;
        armed_next = 1'b0;
      end
      hold_next = {c1_reg[asyntx_pkg::C1_NINTH], wd_reg[7:0]};
      hold_full_next = 1'b1;
    end
    case (st_reg)
      asyntx_pkg::ST_OFF: begin
        if (txen) begin
          st_next = asyntx_pkg::ST_IDLE;
        end
      end
      asyntx_pkg::ST_IDLE: begin
        if (!txen) begin
          st_next = asyntx_pkg::ST_OFF;
        end else if (tick && pend_idle_reg) begin
          sh_next = 11'h7ff;
          nbit_next = frame_bits;
          pend_idle_next = 1'b0;
          st_next = asyntx_pkg::ST_PREAMBLE;
        end else if (tick && brk) begin
          sh_next = 11'h000;
          nbit_next = frame_bits;
          st_next = asyntx_pkg::ST_BRK;
        end else if (tick && hold_full_next) begin
          sh_next = frame_of(hold_next, nine);
          nbit_next = frame_bits;
          hold_full_next = 1'b0;
          empty_next = 1'b1;
          st_next = asyntx_pkg::ST_FRAME;
        end
      end
      asyntx_pkg::ST_PREAMBLE, asyntx_pkg::ST_FRAME,
      asyntx_pkg::ST_BRK, asyntx_pkg::ST_MARK: begin
        if (tick) begin
          sh_next = {1'b1, sh_reg[10:1]};
          nbit_next = nbit_reg - 4'h1;
        end
        if (frame_end) begin
          if (st_reg != asyntx_pkg::ST_PREAMBLE
              && st_reg != asyntx_pkg::ST_MARK) begin
            done_next = 1'b1;
          end
          if (st_reg == asyntx_pkg::ST_BRK && brk) begin
            sh_next = 11'h000;
            nbit_next = frame_bits;
          end else if (st_reg == asyntx_pkg::ST_BRK) begin
            sh_next = 11'h7ff;
            nbit_next = 4'h1;
            st_next = asyntx_pkg::ST_MARK;
          end else if (pend_idle_reg && txen) begin
            sh_next = 11'h7ff;
            nbit_next = frame_bits;
            pend_idle_next = 1'b0;
            st_next = asyntx_pkg::ST_PREAMBLE;
          end else if (hold_full_next && txen && !brk) begin
            sh_next = frame_of(hold_next, nine);
            nbit_next = frame_bits;
            hold_full_next = 1'b0;
            empty_next = 1'b1;
            st_next = asyntx_pkg::ST_FRAME;
          end else begin
            st_next = txen ? asyntx_pkg::ST_IDLE : asyntx_pkg::ST_OFF;
          end
        end
      end
      default: st_next = asyntx_pkg::ST_OFF;
    endcase
  end

  always_comb begin
    oe_next = txen || c2_reg[asyntx_pkg::C2_RXEN]
              || (st_reg != asyntx_pkg::ST_OFF);
    line_next = (st_reg == asyntx_pkg::ST_OFF
                 || st_reg == asyntx_pkg::ST_IDLE) ? 1'b1 : sh_reg[0];
    irq_next = !cpu_irq_mask
               && ((empty_reg && c2_reg[asyntx_pkg::C2_EMPTYIE])
                   || (done_reg && c2_reg[asyntx_pkg::C2_DONEIE]));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c1_reg <= asyntx_pkg::CTRL1_RST;
      c2_reg <= asyntx_pkg::CTRL2_FLAGS_RST;
      div_reg <= asyntx_pkg::DIV_RST;
      bcnt_reg <= asyntx_pkg::DIV_RST;
      hold_reg <= 9'h000;
      hold_full_reg <= 1'b0;
      empty_reg <= 1'b1;
      done_reg <= 1'b1;
      armed_reg <= 1'b0;
      pend_idle_reg <= 1'b0;
      sh_reg <= 11'h7ff;
      nbit_reg <= 4'h0;
      st_reg <= asyntx_pkg::ST_OFF;
      line_reg <= 1'b1;
      oe_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      c1_reg <= c1_next;
      c2_reg <= c2_next;
      div_reg <= div_next;
      bcnt_reg <= bcnt_next;
      hold_reg <= hold_next;
      hold_full_reg <= hold_full_next;
      empty_reg <= empty_next;
      done_reg <= done_next;
      armed_reg <= armed_next;
      pend_idle_reg <= pend_idle_next;
      sh_reg <= sh_next;
      nbit_reg <= nbit_next;
      st_reg <= st_next;
      line_reg <= line_next;
      oe_reg <= oe_next;
      irq_reg <= irq_next;
    end
  end

  assign tx_line_o = line_reg;
  assign tx_line_oe = oe_reg;
  assign irq_o = irq_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  line_idle_a: assert property ((st_reg == asyntx_pkg::ST_IDLE)
    |=> tx_line_o) else $error("line not high while idle");
  pin_free_a: assert property ((!txen && !c2_reg[asyntx_pkg::C2_RXEN]
    && st_reg == asyntx_pkg::ST_OFF) |=> !tx_line_oe)
    else $error("pin held while disabled");
  start_low_a: assert property ((st_reg == asyntx_pkg::ST_FRAME
    && !sh_reg[0]) |=> !tx_line_o) else $error("start bit not low");
  stop_high_a: assert property ((st_reg == asyntx_pkg::ST_FRAME
    && nbit_reg == 4'h1) |=> tx_line_o) else $error("stop not high");
  idle_frame_a: assert property ((st_reg == asyntx_pkg::ST_PREAMBLE)
    |=> tx_line_o) else $error("idle frame has low bit");
  brk_low_a: assert property ((st_reg == asyntx_pkg::ST_BRK)
    |=> !tx_line_o) else $error("break frame has high bit");
  empty_set_a: assert property ((st_reg == asyntx_pkg::ST_IDLE && tick
    && hold_full_reg && !pend_idle_reg && !brk && txen)
    |=> empty_reg && st_reg == asyntx_pkg::ST_FRAME)
    else $error("direct load did not set empty");
  empty_clr_a: assert property ((data_wr && armed_reg
    && !(st_reg == asyntx_pkg::ST_IDLE && tick))
    |=> !empty_reg || st_reg == asyntx_pkg::ST_FRAME)
    else $error("empty not cleared by sequence");
  done_set_a: assert property ((frame_end && (st_reg == asyntx_pkg::ST_FRAME
    || st_reg == asyntx_pkg::ST_BRK)) |=> done_reg)
    else $error("done flag not set at frame end");
  irq_gate_a: assert property (cpu_irq_mask |=> !irq_o)
    else $error("irq while cpu mask set");
  bit_len_a: assert property ($changed(nbit_reg) && nbit_reg != 4'h0
    && $past(tick) |-> bcnt_reg == div_reg || $past(st_reg)
    == asyntx_pkg::ST_IDLE) else $error("uneven bit period");

  frame_c: cover property (st_reg == asyntx_pkg::ST_FRAME && frame_end);
  brk_c: cover property (st_reg == asyntx_pkg::ST_MARK);
  idle_c: cover property (st_reg == asyntx_pkg::ST_PREAMBLE && frame_end);
  irq_c: cover property (irq_o);
endmodule : asyntx_top
`default_nettype wire

// [dv/asyntx_serial_rx.sv]
// asyntx_serial_rx: far-side receiver model sampling the serial line
// assumes: one clock shared with the bench, pull-up on a released pin
`timescale 1ns/1ns
`default_nettype none
module asyntx_serial_rx #(
  parameter int BIT = 250
) (
  input wire logic aclk,
  input wire logic line_o,
  input wire logic line_oe,
  input wire logic nine,
  output var logic [8:0] word,
  output var logic stop_ok,
  output var int frames,
  output var int start_cyc,
  output var int low_len
);
  // ----
  // line level and cycle stamp
  // ----
  logic line;
  logic [8:0] w;
  int cyc = 0;
  assign line = line_oe ? line_o : 1'b1;
  always @(posedge aclk) cyc <= cyc + 1;
  // ----
  // frame hunting and sampling
  // ----
  initial begin
    frames = 0;
    word = '0;
    stop_ok = 1'b0;
    start_cyc = 0;
    low_len = 0;
    forever begin
      @(posedge aclk);
      if (line === 1'b0) begin
        start_cyc = cyc;
        low_len = 0;
        repeat (BIT / 2) @(posedge aclk);
        if (line === 1'b0) begin
          w = '0;
          for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (BIT) @(posedge aclk);
            w[i] = line;
          end
          repeat (BIT) @(posedge aclk);
          stop_ok = line;
          word = w;
          frames++;
          while (line !== 1'b1) @(posedge aclk);
          low_len = cyc - start_cyc;
        end
      end
    end
  end
endmodule : asyntx_serial_rx
`default_nettype wire

// [dv/test_async_serial_transmitter.sv]
// test_async_serial_transmitter: self-checking bench for asyntx_top
// assumes: asyntx_pkg compiled first, receiver model on the serial line
`timescale 1ns/1ns
`default_nettype none
module test_async_serial_transmitter;
  localparam int BIT = 250;
  localparam int F8 = 10 * BIT;
  localparam int F9 = 11 * BIT;
  localparam logic [3:0] A_ST = asyntx_pkg::ADDR_STATUS;
  localparam logic [3:0] A_DT = asyntx_pkg::ADDR_DATA;
  localparam logic [3:0] A_C1 = asyntx_pkg::ADDR_CTRL1;
  localparam logic [3:0] A_C2 = asyntx_pkg::ADDR_CTRL2;
  localparam logic [31:0] TXEN = 32'h1 << asyntx_pkg::C2_TXEN;
  localparam logic [31:0] EIE = 32'h1 << asyntx_pkg::C2_EMPTYIE;
  localparam logic [31:0] DIE = 32'h1 << asyntx_pkg::C2_DONEIE;
  localparam logic [31:0] BRK = 32'h1 << asyntx_pkg::C2_BREAK;
  localparam logic [31:0] S_DN = 32'h1 << asyntx_pkg::ST_DONE;
  localparam logic [31:0] S_EM = 32'h1 << asyntx_pkg::ST_EMPTY;
  localparam logic [31:0] S_BY = 32'h1 << asyntx_pkg::ST_BUSY;
  localparam logic [31:0] W9 = 32'h3;
  logic aclk, aresetn, cpu_irq_mask, nine, rx_stop;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, tx_line_o, tx_line_oe, irq_o;
  logic [8:0] rx_word;
  int rx_frames, rx_start, rx_low, mismatches, samples_checked, t0;
  int cyc = 0;
  asyntx_top asyntx_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_irq_mask, .tx_line_o, .tx_line_oe,
    .irq_o);
  asyntx_serial_rx #(.BIT(BIT)) asyntx_serial_rx_i (.aclk,
    .line_o(tx_line_o), .line_oe(tx_line_oe), .nine, .word(rx_word),
    .stop_ok(rx_stop), .frames(rx_frames), .start_cyc(rx_start),
    .low_len(rx_low));
  // ----
  // clock, cycle count, watchdog
  // ----
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  initial begin
    repeat (80000) @(posedge aclk);
    mismatches++;
    $display("[ERR] t=%0t frames=%h want=%h", $time, rx_frames, 6);
    complete_run();
  end
  // ----
  // tasks
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic wait_frames(input int n);
    while (rx_frames < n) @(posedge aclk);
  endtask : wait_frames
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // ----
  // test sequence
  // ----
  initial begin
    aresetn = 1'b0;
    cpu_irq_mask = 1'b0;
    nine = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(tx_line_oe, 1'b0);
    axi_rd(A_ST);
    check(rd, S_DN | S_EM);
    check(rsp, asyntx_pkg::RESP_OKAY);
    axi_wr(4'h2, 32'h0);
    check(rsp, asyntx_pkg::RESP_SLVERR);
    axi_rd(4'h2);
    check(rsp, asyntx_pkg::RESP_SLVERR);
    check(rd, 32'h0);
    axi_wr(A_C1, 32'h0);
    check(rsp, asyntx_pkg::RESP_OKAY);
    axi_wr(A_C2, TXEN);
    repeat (F8 + 2 * BIT) @(posedge aclk);
    check({tx_line_oe, tx_line_o}, 2'h3);
    axi_rd(A_ST);
    axi_wr(A_DT, 32'ha5);
    repeat (BIT + 2) @(posedge aclk);
    axi_rd(A_ST);
    check(rd, S_EM | S_BY);
    axi_wr(A_DT, 32'h3c);
    axi_rd(A_ST);
    check(rd, S_BY);
    wait_frames(1);
    check({rx_stop, rx_word}, 10'h2a5);
    t0 = rx_start;
    wait_frames(2);
    check({rx_stop, rx_word}, 10'h23c);
    check(rx_start - t0, F8);
    repeat (BIT) @(posedge aclk);
    axi_rd(A_ST);
    check(rd, S_DN | S_EM);
    for (int i = 0; i < 4; i++) begin
      cpu_irq_mask <= i[0];
      axi_wr(A_C2, TXEN | (i < 2 ? EIE : DIE));
      repeat (3) @(posedge aclk);
      check(irq_o, !i[0]);
    end
    axi_wr(A_C2, 32'h0);
    repeat (3) @(posedge aclk);
    check(tx_line_oe, 1'b0);
    axi_wr(A_C1, W9);
    nine <= 1'b1;
    axi_wr(A_C2, TXEN);
    t0 = cyc;
    axi_rd(A_ST);
    axi_wr(A_DT, 32'h5a);
    wait_frames(3);
    check({rx_stop, rx_word}, 10'h35a);
    check(rx_start - t0 >= F9 - 4, 1'b1);
    repeat (2 * BIT) @(posedge aclk);
    axi_rd(A_ST);
    axi_wr(A_DT, 32'h81);
    repeat (3 * BIT) @(posedge aclk);
    axi_wr(A_C2, 32'h0);
    axi_wr(A_C2, TXEN);
    axi_rd(A_ST);
    axi_wr(A_DT, 32'h7e);
    wait_frames(4);
    check({rx_stop, rx_word}, 10'h381);
    t0 = rx_start;
    wait_frames(5);
    check({rx_stop, rx_word}, 10'h37e);
    check(rx_start - t0 >= 2 * F9, 1'b1);
    axi_wr(A_C2, TXEN | BRK);
    wait_frames(6);
    check({rx_stop, rx_word}, 10'h000);
    repeat (F9) @(posedge aclk);
    axi_wr(A_C2, TXEN);
    while (rx_low == 0) @(posedge aclk);
    check(rx_low, 2 * F9);
    repeat (2 * BIT) @(posedge aclk);
    check(tx_line_o, 1'b1);
    axi_rd(A_ST);
    check(rd & S_DN, S_DN);
    complete_run();
  end
endmodule : test_async_serial_transmitter
`default_nettype wire
